// [shared/exec_slice_defs.svh]
// Constants for the jump, increment, OR and shift execution slice
// Summary of operation
// - Jump loads 11-bit literal into PC[10:0].
// - Jump takes PC[14:11] from latch bits 6:3.
// - Jump takes two cycles, flags untouched.
// - File address 0..127; dest bit picks target.
// - Add-one writes f+1, updates zero flag.
// - Add-one-skip writes f+1, zero result skips next.
// - OR literal into accumulator, updates zero flag.
// - OR accumulator with file to dest, zero flag.
// - Left shift: bit7 to carry, zero in.
// - Right shift: bit0 to carry, zero in.
`ifndef EXEC_SLICE_DEFS_SVH
`define EXEC_SLICE_DEFS_SVH
`define PC_WIDTH        15
`define JUMP_LIT_WIDTH  11
`define FILE_ADDR_WIDTH 7
`define LATCH_HI_BIT    6
`define LATCH_LO_BIT    3
`define DATA_RESET      8'h00
`define PC_RESET        15'h0000
`define FLAG_RESET      1'b0
`define JUMP_CYCLES     2'h2
`endif

// [shared/exec_slice_pkg.sv]
// Types for the jump, increment, OR and shift execution slice
package exec_slice_pkg;
    // Operation selector from the instruction decoder
    typedef enum logic [2:0] {
        OP_NONE              = 3'h0,
        OP_JUMP_ABSOLUTE     = 3'h1,
        OP_ADD_ONE_FILE      = 3'h2,
        OP_ADD_ONE_SKIP_ZERO = 3'h3,
        OP_OR_LITERAL_ACC    = 3'h4,
        OP_OR_ACC_FILE       = 3'h5,
        OP_SHIFT_LEFT_FILE   = 3'h6,
        OP_SHIFT_RIGHT_FILE  = 3'h7
    } exec_op_t;
    // Sequencer states, one-hot
    typedef enum logic [1:0] {
        ST_EXEC  = 2'b01,
        ST_FLUSH = 2'b10
    } exec_state_t;
endpackage

// [rtl/slice_alu.sv]
// Combinational result and flag generator for the slice
`timescale 1ns/1ps
`include "exec_slice_defs.svh"
module slice_alu import exec_slice_pkg::*; (
    // Operation and operands
    input  wire exec_op_t   op,
    input  wire logic [7:0] accIn,
    input  wire logic [7:0] fileIn,
    input  wire logic [7:0] literal,
    // Result and flags
    output logic [7:0]      result,
    output logic            carryOut,
    output logic            carryWrite,
    output logic            zeroWrite,
    output logic            isZero
);
    // Compute result per operation
    always_comb begin
        result     = `DATA_RESET;
        carryOut   = 1'b0;
        carryWrite = 1'b0;
        zeroWrite  = 1'b0;
        case (op)
            OP_ADD_ONE_FILE: begin
                result    = fileIn + 8'h01;
                zeroWrite = 1'b1;
            end
            OP_ADD_ONE_SKIP_ZERO: begin
                result = fileIn + 8'h01;
            end
            OP_OR_LITERAL_ACC: begin
                result    = accIn | literal;
                zeroWrite = 1'b1;
            end
            OP_OR_ACC_FILE: begin
                result    = accIn | fileIn;
                zeroWrite = 1'b1;
            end
            OP_SHIFT_LEFT_FILE: begin
                result     = {fileIn[6:0], 1'b0};
                carryOut   = fileIn[7];
                carryWrite = 1'b1;
                zeroWrite  = 1'b1;
            end
            OP_SHIFT_RIGHT_FILE: begin
                result     = {1'b0, fileIn[7:1]};
                carryOut   = fileIn[0];
                carryWrite = 1'b1;
                zeroWrite  = 1'b1;
            end
            default: begin
                result = `DATA_RESET;
            end
        endcase
        isZero = (result == 8'h00);
    end
endmodule // slice_alu

// [rtl/branch_increment_or_shift_exec.sv]
// Execution slice: jump, add-one, add-one-skip, OR and logical shifts
`timescale 1ns/1ps
`include "exec_slice_defs.svh"
module branch_increment_or_shift_exec import exec_slice_pkg::*; (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        reset,
    // Decoded instruction
    input  wire logic                        instrValid,
    input  wire exec_op_t                    instrOp,
    input  wire logic [`FILE_ADDR_WIDTH-1:0] fileAddr,
    input  wire logic                        destToFile,
    input  wire logic [10:0]                 jumpTarget,
    input  wire logic [7:0]                  literal,
    // Operand sources
    input  wire logic [7:0]                  fileRdData,
    input  wire logic [7:0]                  upperPcLatch,
    // Execution status to the decoder
    output logic                             busy,
    output logic                             flushNext,
    // File register write port
    output logic                             fileWrEn,
    output logic [`FILE_ADDR_WIDTH-1:0]      fileWrAddr,
    output logic [7:0]                       fileWrData,
    // Architectural state
    output logic [7:0]                       acc,
    output logic                             zeroFlag,
    output logic                             carryFlag,
    output logic                             pcLoad,
    output logic [`PC_WIDTH-1:0]             pcValue
);
    // All state in one struct
    typedef struct packed {
        exec_state_t                 st;
        logic [7:0]                  acc;
        logic                        zero;
        logic                        carry;
        logic                        wrEn;
        logic [`FILE_ADDR_WIDTH-1:0] wrAddr;
        logic [7:0]                  wrData;
        logic                        pcLoad;
        logic [`PC_WIDTH-1:0]        pc;
        logic                        flush;
    } state_t;

    state_t s_q;         // Registered state
    state_t s_d;         // Next state
    logic [7:0] res;     // ALU result
    logic       cOut;    // ALU carry
    logic       cWr;     // Carry write enable
    logic       zWr;     // Zero write enable
    logic       resZero; // Result is zero
    logic       start;   // Instruction accepted this cycle
    logic [7:0] fileOperand; // File operand with the last write forwarded

    // Result generator
    slice_alu alu (
        .op        (instrOp),
        .accIn     (s_q.acc),
        .fileIn    (fileOperand),
        .literal   (literal),
        .result    (res),
        .carryOut  (cOut),
        .carryWrite(cWr),
        .zeroWrite (zWr),
        .isZero    (resZero)
    );

    // An instruction is taken only outside the dead cycle
    assign start = instrValid && (s_q.st == ST_EXEC);

    // A write still in flight lands on the same edge that takes the next
    // instruction, so its data must win over the stale read value
    assign fileOperand = (s_q.wrEn && s_q.wrAddr == fileAddr) ? s_q.wrData : fileRdData;

    // Next-state logic
    always_comb begin
        s_d        = s_q;
        s_d.wrEn   = 1'b0;
        s_d.pcLoad = 1'b0;
        s_d.flush  = 1'b0;
        case (s_q.st)
            ST_EXEC: begin
                if (start) begin
                    if (instrOp == OP_JUMP_ABSOLUTE) begin
                        // Target built from latch and literal, flags kept
                        s_d.pc = {upperPcLatch[`LATCH_HI_BIT:`LATCH_LO_BIT],
                                  jumpTarget};
                        s_d.pcLoad = 1'b1;
                        s_d.flush  = 1'b1;
                        s_d.st     = ST_FLUSH;
                    end else if (instrOp != OP_NONE) begin
                        // Destination select; literal OR always targets acc
                        if (destToFile && instrOp != OP_OR_LITERAL_ACC) begin
                            s_d.wrEn   = 1'b1;
                            s_d.wrAddr = fileAddr;
                            s_d.wrData = res;
                        end else begin
                            s_d.acc = res;
                        end
                        if (zWr) begin
                            s_d.zero = resZero;
                        end
                        if (cWr) begin
                            s_d.carry = cOut;
                        end
                        if (instrOp == OP_ADD_ONE_SKIP_ZERO && resZero) begin
                            s_d.flush = 1'b1;
                            s_d.st    = ST_FLUSH;
                        end
                    end
                end
            end
            ST_FLUSH: begin
                // Second cycle executes as a no-operation
                s_d.st = ST_EXEC;
            end
            default: begin
                s_d.st = ST_EXEC;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q.st     <= ST_EXEC;
            s_q.acc    <= `DATA_RESET;
            s_q.zero   <= `FLAG_RESET;
            s_q.carry  <= `FLAG_RESET;
            s_q.wrEn   <= 1'b0;
            s_q.wrAddr <= '0;
            s_q.wrData <= `DATA_RESET;
            s_q.pcLoad <= 1'b0;
            s_q.pc     <= `PC_RESET;
            s_q.flush  <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign busy       = (s_q.st == ST_FLUSH);
    assign flushNext  = s_q.flush;
    assign fileWrEn   = s_q.wrEn;
    assign fileWrAddr = s_q.wrAddr;
    assign fileWrData = s_q.wrData;
    assign acc        = s_q.acc;
    assign zeroFlag   = s_q.zero;
    assign carryFlag  = s_q.carry;
    assign pcLoad     = s_q.pcLoad;
    assign pcValue    = s_q.pc;

    // Two-cycle sequence for jumps and taken skips
    sequence seqTwoCycle;
        busy ##1 !busy;
    endsequence

    chk_jump_target: assert property (@(posedge clk) disable iff (reset)
        start && instrOp == OP_JUMP_ABSOLUTE |=> pcLoad &&
        pcValue == {$past(upperPcLatch[6:3]), $past(jumpTarget)})
        else $error("jump target wrong");
    chk_jump_two: assert property (@(posedge clk) disable iff (reset)
        start && instrOp == OP_JUMP_ABSOLUTE |=> seqTwoCycle)
        else $error("jump not two cycles");
    chk_jump_flags: assert property (@(posedge clk) disable iff (reset)
        start && instrOp == OP_JUMP_ABSOLUTE |=> $stable(zeroFlag) && $stable(carryFlag))
        else $error("jump changed flags");
    chk_file_dest: assert property (@(posedge clk) disable iff (reset)
        start && instrOp inside {OP_ADD_ONE_FILE, OP_OR_ACC_FILE} && destToFile
        |=> fileWrEn && fileWrAddr == $past(fileAddr) && $stable(acc))
        else $error("file destination wrong");
    chk_add_one: assert property (@(posedge clk) disable iff (reset)
        start && instrOp == OP_ADD_ONE_FILE && !destToFile
        |=> acc == 8'($past(fileOperand) + 8'h01) && zeroFlag == (acc == 8'h00))
        else $error("add one wrong");
    chk_skip_zero: assert property (@(posedge clk) disable iff (reset)
        start && instrOp == OP_ADD_ONE_SKIP_ZERO
        |=> flushNext == ($past(fileOperand) == 8'hff) && $stable(zeroFlag))
        else $error("skip decision wrong");
    chk_or_literal: assert property (@(posedge clk) disable iff (reset)
        start && instrOp == OP_OR_LITERAL_ACC
        |=> acc == ($past(acc) | $past(literal)) && !fileWrEn)
        else $error("or literal wrong");
    chk_or_file: assert property (@(posedge clk) disable iff (reset)
        start && instrOp == OP_OR_ACC_FILE && destToFile
        |=> fileWrData == ($past(acc) | $past(fileOperand)))
        else $error("or file wrong");
    chk_shift_left: assert property (@(posedge clk) disable iff (reset)
        start && instrOp == OP_SHIFT_LEFT_FILE && !destToFile
        |=> carryFlag == $past(fileOperand[7]) && acc == {$past(fileOperand[6:0]), 1'b0})
        else $error("left shift wrong");
    chk_shift_right: assert property (@(posedge clk) disable iff (reset)
        start && instrOp == OP_SHIFT_RIGHT_FILE && !destToFile
        |=> carryFlag == $past(fileOperand[0]) && acc == {1'b0, $past(fileOperand[7:1])})
        else $error("right shift wrong");
    chk_one_cycle: assert property (@(posedge clk) disable iff (reset)
        start && instrOp inside {OP_ADD_ONE_FILE, OP_OR_LITERAL_ACC, OP_OR_ACC_FILE,
        OP_SHIFT_LEFT_FILE, OP_SHIFT_RIGHT_FILE} |=> !busy)
        else $error("single cycle op stalled");

    // Skip decision, dead cycle and chained results
    chk_skip_two: assert property (@(posedge clk) disable iff (reset)
        start && instrOp == OP_ADD_ONE_SKIP_ZERO && fileOperand == 8'hff |=> seqTwoCycle)
        else $error("taken skip not two cycles");
    chk_skip_not_taken: assert property (@(posedge clk) disable iff (reset)
        start && instrOp == OP_ADD_ONE_SKIP_ZERO && fileOperand != 8'hff
        |=> !busy && !flushNext)
        else $error("skip taken on nonzero result");
    chk_dead_ignored: assert property (@(posedge clk) disable iff (reset)
        busy |=> !fileWrEn && !pcLoad && $stable(acc)
        && $stable(zeroFlag) && $stable(carryFlag))
        else $error("dead cycle changed state");
    chk_zero_update: assert property (@(posedge clk) disable iff (reset)
        start && (instrOp == OP_OR_LITERAL_ACC || (instrOp == OP_OR_ACC_FILE && !destToFile))
        |=> zeroFlag == (acc == 8'h00))
        else $error("zero flag not updated");
    chk_result_forward: assert property (@(posedge clk) disable iff (reset)
        start && fileWrEn && fileAddr == fileWrAddr && instrOp == OP_ADD_ONE_FILE
        && !destToFile |=> acc == 8'($past(fileWrData) + 8'h01))
        else $error("file result not forwarded");
endmodule // branch_increment_or_shift_exec

// [verif/file_space_model.sv]
// Behavioural file register space that feeds and absorbs the execution slice
`timescale 1ns/1ps
`include "exec_slice_defs.svh"
module file_space_model (
    // Clock
    input  wire logic                        clk,
    // Read side, driven by the decoder address
    input  wire logic [`FILE_ADDR_WIDTH-1:0] fileAddr,
    output logic [7:0]                       fileRdData,
    // Write side from the slice
    input  wire logic                        fileWrEn,
    input  wire logic [`FILE_ADDR_WIDTH-1:0] fileWrAddr,
    input  wire logic [7:0]                  fileWrData
);
    // Full 128-entry space, preloaded by the bench
    logic [7:0] mem [128];

    // Read is combinational so the operand is there in the issue cycle
    assign fileRdData = mem[fileAddr];

    // Write lands on the edge that takes the next instruction, so only later reads see it
    always @(posedge clk) begin
        if (fileWrEn === 1'b1) mem[fileWrAddr] <= fileWrData;
    end
endmodule // file_space_model

// [verif/test_branch_increment_or_shift_exec.sv]
// Self-checking random bench for the execution slice
`timescale 1ns/1ps
`include "exec_slice_defs.svh"
module test_branch_increment_or_shift_exec;
    import exec_slice_pkg::*;
    // Stimulus
    logic clk = 1'b0, reset = 1'b1, instrValid = 1'b0, destToFile = 1'b0;
    exec_op_t    instrOp = OP_NONE;
    logic [6:0]  fileAddr = 7'h00;
    logic [10:0] jumpTarget = 11'h000;
    logic [7:0]  literal = 8'h00, upperPcLatch = 8'h00;
    // Observed outputs
    logic [7:0]  fileRdData, fileWrData, acc;
    logic [6:0]  fileWrAddr;
    logic [14:0] pcValue;
    logic        busy, flushNext, fileWrEn, zeroFlag, carryFlag, pcLoad;
    // Reference state
    logic [7:0]  shadow [128];
    logic [7:0]  eAcc = 8'h00;
    logic        eZ = 1'b0, eC = 1'b0;
    int          miscompares = 0, num_checks = 0, seed = 37;

    always #20 clk = ~clk;

    branch_increment_or_shift_exec i_dut (.clk(clk), .reset(reset),
        .instrValid(instrValid), .instrOp(instrOp), .fileAddr(fileAddr),
        .destToFile(destToFile), .jumpTarget(jumpTarget), .literal(literal),
        .fileRdData(fileRdData), .upperPcLatch(upperPcLatch), .busy(busy),
        .flushNext(flushNext), .fileWrEn(fileWrEn), .fileWrAddr(fileWrAddr),
        .fileWrData(fileWrData), .acc(acc), .zeroFlag(zeroFlag),
        .carryFlag(carryFlag), .pcLoad(pcLoad), .pcValue(pcValue));
    file_space_model i_file (.clk(clk), .fileAddr(fileAddr), .fileRdData(fileRdData),
        .fileWrEn(fileWrEn), .fileWrAddr(fileWrAddr), .fileWrData(fileWrData));

    // Compare one value and count the outcome
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Expected {carry, result} of one operation
    function automatic logic [8:0] alu(exec_op_t op, logic [7:0] a, f, k);
        case (op)
            OP_ADD_ONE_FILE, OP_ADD_ONE_SKIP_ZERO: alu = {1'b0, f + 8'h01};
            OP_OR_LITERAL_ACC:   alu = {1'b0, a | k};
            OP_OR_ACC_FILE:      alu = {1'b0, a | f};
            OP_SHIFT_LEFT_FILE:  alu = {f[7], f[6:0], 1'b0};
            OP_SHIFT_RIGHT_FILE: alu = {f[0], 1'b0, f[7:1]};
            default:             alu = 9'h000;
        endcase
    endfunction

    // Issue one instruction at a falling edge and check its results
    task run(input exec_op_t op, input logic [6:0] a, input logic d,
             input logic [10:0] jt, input logic [7:0] k);
        logic [7:0] r;
        logic c, toFile, skip, jmp;
        {c, r} = alu(op, eAcc, shadow[a], k);
        jmp = (op == OP_JUMP_ABSOLUTE);
        skip = (op == OP_ADD_ONE_SKIP_ZERO) && (r == 8'h00);
        toFile = d && !jmp && op != OP_NONE && op != OP_OR_LITERAL_ACC;
        instrOp = op; fileAddr = a; destToFile = d; jumpTarget = jt; literal = k;
        upperPcLatch = 8'($random(seed));
        instrValid = 1'b1;
        @(negedge clk);
        check(fileWrEn, toFile);
        if (toFile) begin
            check(fileWrAddr, a);
            check(fileWrData, r);
            shadow[a] = r;
        end else if (!jmp && op != OP_NONE) eAcc = r;
        if (op inside {OP_ADD_ONE_FILE, OP_OR_LITERAL_ACC, OP_OR_ACC_FILE,
                       OP_SHIFT_LEFT_FILE, OP_SHIFT_RIGHT_FILE}) eZ = (r == 8'h00);
        if (op inside {OP_SHIFT_LEFT_FILE, OP_SHIFT_RIGHT_FILE}) eC = c;
        check(acc, eAcc);
        check({zeroFlag, carryFlag}, {eZ, eC});
        check(pcLoad, jmp);
        if (jmp) check(pcValue, {upperPcLatch[6:3], jt});
        check(busy, jmp || skip);
        check(flushNext, jmp || skip);
        if (jmp || skip) begin
            // Offer an instruction in the dead cycle; it must be ignored
            instrOp = OP_OR_LITERAL_ACC;
            literal = 8'hFF;
            @(negedge clk);
            check({busy, acc}, {1'b0, eAcc});
        end
    endtask

    // Counts, verdict and end of run
    task report_and_stop;
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Watchdog sized well beyond the few hundred cycles of the run
    initial begin
        #(40 * 3000);
        miscompares++;
        report_and_stop;
    end

    // Main sequence: reset, corner cases, then random traffic
    initial begin
        for (int i = 0; i < 128; i++) shadow[i] = 8'($random(seed));
        shadow[127] = 8'hFF;
        shadow[1] = 8'h80;
        shadow[2] = 8'h01;
        for (int i = 0; i < 128; i++) i_file.mem[i] = shadow[i];
        repeat (2) @(negedge clk);
        reset = 1'b0;
        check({busy, flushNext, fileWrEn, pcLoad, acc, zeroFlag, carryFlag, pcValue}, 0);
        run(OP_OR_LITERAL_ACC, 7'h00, 1'b0, 11'h000, 8'h00);
        run(OP_ADD_ONE_SKIP_ZERO, 7'h7F, 1'b1, 11'h000, 8'h00);
        run(OP_ADD_ONE_FILE, 7'h7F, 1'b0, 11'h000, 8'h00);
        run(OP_SHIFT_LEFT_FILE, 7'h01, 1'b1, 11'h000, 8'h00);
        run(OP_SHIFT_RIGHT_FILE, 7'h02, 1'b0, 11'h000, 8'h00);
        run(OP_JUMP_ABSOLUTE, 7'h00, 1'b0, 11'h7FF, 8'h00);
        run(OP_ADD_ONE_FILE, 7'h05, 1'b1, 11'h000, 8'h00);
        run(OP_ADD_ONE_FILE, 7'h05, 1'b0, 11'h000, 8'h00);
        for (int i = 0; i < 300; i++)
            run(exec_op_t'(3'($random(seed))), 7'($random(seed)), 1'($random(seed)),
                11'($random(seed)), 8'($random(seed)));
        instrValid = 1'b0;
        @(negedge clk);
        report_and_stop;
    end
endmodule // test_branch_increment_or_shift_exec
